// [rtl/crs_top.sv]
`timescale 1ns/1ps
`default_nettype none
// Overview of operation
// - Data breakpoint in concurrent or triggered mode halts on the very next cycle.
// - A scan requested in the breakpoint cycle waits until debug exit.
// - In burst mode an external halt interrupts the burst after the access.
// - In concurrent or triggered mode, single step with a scan ready performs the read, then halts again.
// - In concurrent or triggered mode, a scan that would stall a software breakpoint completes first, then halts.
// - Breakpoint on the burst go instruction halts; exit sets go, burst completes.
// - CRC unit and scanner each disabled by their own disable bit.
// - Scanner disable counts only if scanner is available; else scanner unusable.
// - CRC enable bit releases unit from reset; clear holds it idle.
// - CRC go bit runs the shifter; clearing it stops shifting.
// - CRC busy reads 1 while shifting or pending, 0 when shifter empty.
// - Accumulate mode bit selects zero augmentation of the data.
// - Shift direction bit: 1 shifts right LSB first, 0 left MSB first.
// - Full flag reads 1 until the data word moves into the shifter.
// - Word length field plus one bits are shifted per word.
// - Polynomial length field plus one sets the active accumulator width.
// - Scan mode 11 triggered, 10 peek, 01 burst, 00 concurrent.
// - Scanner freezes during debug halt, state stays readable.
// - With go set, scanner reads memory when CRC ready, feeds the CRC.
module crs_top
	import crs_pkg::*;
(
	// Clock and reset
	input  wire logic              clock,
	input  wire logic              rstn,
	// Register port
	input  wire logic [11:0]       addr,
	input  wire logic [7:0]        wdata,
	input  wire logic              wr,
	input  wire logic              rd,
	output logic      [7:0]        rdata,
	// Module disable and configuration
	input  wire logic              checksum_unit_disable,
	input  wire logic              scanner_unit_disable,
	input  wire logic              scanner_available_config,
	// Memory read port
	output logic                   nvm_req,
	output logic      [NVM_AW-1:0] nvm_addr,
	input  wire logic              nvm_ack,
	input  wire logic [15:0]       nvm_data,
	// Core status and triggers
	input  wire logic              cpu_dead_cycle,
	input  wire logic              cpu_in_interrupt,
	input  wire logic [15:0]       triggers,
	output logic                   cpu_stall,
	// Debug
	input  wire logic              ext_halt_req,
	input  wire logic              data_breakpoint,
	input  wire logic              single_step,
	input  wire logic              software_breakpoint,
	input  wire logic              software_breakpoint_on_go,
	input  wire logic              debug_exit,
	output logic                   debug_halt
);

	logic [21:0] low_addr;
	logic [21:0] high_addr;
	logic        setup;
	logic        scan_en;
	logic        scan_go;
	logic        interrupt_priority_select;
	crs_mode_t   mode;
	logic [3:0]  trig_sel;
	logic        trig_pend;
	logic        reading;
	crs_dbg_t    dbg;
	logic        wait_start;
	logic        resume_go;
	logic [7:0]  crc_con;
	logic [7:0]  len_cfg;
	logic [15:1] taps;
	logic [7:0]  next_rdata;
	crs_cfg_t    cfg;
	logic [15:0] data_word;
	logic [15:0] acc;
	logic [15:0] shifter;
	logic        full;
	logic        crc_busy;
	logic        crc_clear;
	logic        crc_wr;
	logic        scan_wr;
	logic        scan_usable;
	logic        invalid;
	logic        trig_hit;
	logic        mode_ok;
	logic        int_block;
	logic        scan_want;
	logic        start;
	logic        done;
	logic        cc_mode;
	logic [1:0]  dat_we;
	logic [1:0]  acc_we;

	// ==========================================
	// Byte lane of a wide register
	function automatic logic [7:0] lane(input logic [23:0] w,
		input logic [1:0] k);
		lane = w[8*k +: 8];
	endfunction : lane

	// ==========================================
	// Enables and scan conditions
	assign crc_clear   = !crc_con[CC_EN] || checksum_unit_disable;
	assign crc_wr      = wr && !checksum_unit_disable;
	assign scan_usable = scanner_available_config && !scanner_unit_disable
		&& scan_en;
	assign scan_wr     = wr && scanner_available_config
		&& !scanner_unit_disable;
	assign invalid     = !setup || (low_addr > high_addr);
	assign trig_hit    = triggers[trig_sel];
	assign cc_mode     = (mode == SM_CONC) || (mode == SM_TRIG);
	assign int_block   = interrupt_priority_select && cpu_in_interrupt && (mode != SM_PEEK);
	assign done        = reading && nvm_ack;

	always_comb begin
		unique case (mode)
			SM_CONC:  mode_ok = 1'b1;
			SM_BURST: mode_ok = 1'b1;
			SM_PEEK:  mode_ok = cpu_dead_cycle;
			SM_TRIG:  mode_ok = trig_pend || trig_hit;
		endcase
	end

	assign scan_want = scan_usable && scan_go && !invalid && !full
		&& !reading && mode_ok && !int_block;
	assign start = scan_want && !data_breakpoint
		&& ((dbg == DBG_RUN) || ((dbg == DBG_WAIT) && wait_start));
	assign cpu_stall = (reading && (mode != SM_PEEK))
		|| ((mode == SM_BURST) && scan_go && scan_usable && !int_block
		&& (dbg == DBG_RUN));
	assign debug_halt = (dbg == DBG_HALT);
	assign nvm_req    = reading;
	assign nvm_addr   = low_addr;

	// ==========================================
	// CRC configuration
	assign cfg.taps = {taps, 1'b1};
	assign cfg.word_length_minus_one = len_cfg[7:4];
	assign cfg.poly_length_minus_one = len_cfg[3:0];
	assign cfg.zero_augment_select = crc_con[CC_ZERO_AUGMENT_SELECT];
	assign cfg.shr  = crc_con[CC_SHR];
	assign cfg.go   = crc_con[CC_GO];
	assign dat_we   = {crc_wr && (addr == OFS_DATA + BYTE1),
		crc_wr && (addr == OFS_DATA)};
	assign acc_we   = {crc_wr && (addr == OFS_ACC + BYTE1),
		crc_wr && (addr == OFS_ACC)};

	crs_core #(
		.W (16)
	) u_core (
		.clock      (clock),
		.rstn       (rstn),
		.clear      (crc_clear),
		.cfg        (cfg),
		.dat_we     (dat_we),
		.load_valid (done),
		.load_data  (nvm_data),
		.acc_we     (acc_we),
		.wbyte      (wdata),
		.data_word  (data_word),
		.acc        (acc),
		.shifter    (shifter),
		.full       (full),
		.busy       (crc_busy)
	);

	// ==========================================
	// CRC registers
	always_ff @(posedge clock or negedge rstn) begin
		if (!rstn) begin
			crc_con <= CRC_CON_RST;
			len_cfg <= LEN_CFG_RST;
			taps    <= '0;
		end else if (crc_wr) begin
			unique case (addr)
				OFS_CRC_CON: crc_con <= wdata;
				OFS_LEN_CFG: len_cfg <= wdata;
				OFS_TAPS: taps[7:1] <= wdata[7:1];
				OFS_TAPS + BYTE1: taps[15:8] <= wdata;
				default: ;
			endcase
		end
	end

	// ==========================================
	// Scanner control
	always_ff @(posedge clock or negedge rstn) begin
		if (!rstn) begin
			scan_en  <= 1'b0;
			interrupt_priority_select     <= 1'b0;
			mode     <= SM_CONC;
			trig_sel <= 4'h0;
		end else if (scan_wr && (addr == OFS_SCAN_CON)) begin
			scan_en <= wdata[SC_EN];
			interrupt_priority_select    <= wdata[SC_INTERRUPT_PRIORITY_SELECT];
			mode    <= crs_mode_t'(wdata[1:0]);
		end else if (scan_wr && (addr == OFS_TRIG_SEL)) begin
			trig_sel <= wdata[3:0];
		end
	end

	// Go bit: hardware clears, software set wins
	always_ff @(posedge clock or negedge rstn) begin
		if (!rstn)
			scan_go <= 1'b0;
		else if (!scan_usable && !(scan_wr && (addr == OFS_SCAN_CON)))
			scan_go <= 1'b0;
		else if (scan_wr && (addr == OFS_SCAN_CON))
			scan_go <= wdata[SC_GO] && wdata[SC_EN];
		else if (debug_halt && debug_exit && resume_go)
			scan_go <= 1'b1;
		else if (invalid || (done && (low_addr == high_addr)))
			scan_go <= 1'b0;
	end

	// Address registers
	always_ff @(posedge clock or negedge rstn) begin
		if (!rstn) begin
			low_addr  <= ADDR_RST;
			high_addr <= ADDR_RST;
			setup     <= 1'b0;
		end else if (scan_wr) begin
			unique case (addr)
				OFS_LOW_ADDR: low_addr[7:0] <= wdata;
				OFS_LOW_ADDR + BYTE1: low_addr[15:8] <= wdata;
				OFS_LOW_ADDR + BYTE2: low_addr[21:16] <= wdata[5:0];
				OFS_HIGH_ADDR: high_addr[7:0] <= wdata;
				OFS_HIGH_ADDR + BYTE1: high_addr[15:8] <= wdata;
				OFS_HIGH_ADDR + BYTE2: high_addr[21:16] <= wdata[5:0];
				default: ;
			endcase
			if ((addr >= OFS_HIGH_ADDR) && (addr <= OFS_HIGH_ADDR + BYTE2))
				setup <= 1'b1;
		end else if (done) begin
			low_addr <= low_addr + 22'h000001;
		end
	end

	// Trigger latch, consumption wins over a new trigger
	always_ff @(posedge clock or negedge rstn) begin
		if (!rstn)
			trig_pend <= 1'b0;
		else if (!scan_usable)
			trig_pend <= 1'b0;
		else if ((mode == SM_TRIG) && trig_hit && !start)
			trig_pend <= 1'b1;
		else if (start)
			trig_pend <= 1'b0;
	end

	// Memory access
	always_ff @(posedge clock or negedge rstn) begin
		if (!rstn)
			reading <= 1'b0;
		else if (start)
			reading <= 1'b1;
		else if (done || !scan_usable)
			reading <= 1'b0;
	end

	// ==========================================
	// Debug halt sequencing
	always_ff @(posedge clock or negedge rstn) begin
		if (!rstn) begin
			dbg        <= DBG_RUN;
			wait_start <= 1'b0;
			resume_go  <= 1'b0;
		end else begin
			unique case (dbg)
				DBG_RUN: begin
					if (data_breakpoint) begin
						dbg <= DBG_HALT;
					end else if (software_breakpoint_on_go && (mode == SM_BURST)) begin
						dbg       <= DBG_HALT;
						resume_go <= 1'b1;
					end else if (ext_halt_req) begin
						dbg <= reading ? DBG_WAIT : DBG_HALT;
						wait_start <= 1'b0;
					end else if ((single_step || software_breakpoint)
						&& cc_mode && (reading || scan_want)) begin
						dbg <= DBG_WAIT;
						wait_start <= !reading;
					end else if (single_step || software_breakpoint) begin
						dbg <= DBG_HALT;
					end
				end
				DBG_WAIT: begin
					if (start)
						wait_start <= 1'b0;
					else if (done || !reading)
						dbg <= DBG_HALT;
				end
				DBG_HALT: begin
					if (debug_exit) begin
						dbg       <= DBG_RUN;
						resume_go <= 1'b0;
					end
				end
				default: dbg <= DBG_RUN;
			endcase
		end
	end

	// ==========================================
	// Register read
	always_comb begin
		unique case (addr)
			OFS_LOW_ADDR: next_rdata = lane({2'b0, low_addr}, 2'd0);
			OFS_LOW_ADDR + BYTE1: next_rdata = lane({2'b0, low_addr}, 2'd1);
			OFS_LOW_ADDR + BYTE2: next_rdata = lane({2'b0, low_addr}, 2'd2);
			OFS_HIGH_ADDR: next_rdata = lane({2'b0, high_addr}, 2'd0);
			OFS_HIGH_ADDR + BYTE1: next_rdata = lane({2'b0, high_addr}, 2'd1);
			OFS_HIGH_ADDR + BYTE2: next_rdata = lane({2'b0, high_addr}, 2'd2);
			OFS_SCAN_CON: next_rdata = {scan_en, scan_go, reading, invalid,
				interrupt_priority_select, 1'b0, mode};
			OFS_TRIG_SEL: next_rdata = {4'h0, trig_sel};
			OFS_DATA: next_rdata = lane({8'h00, data_word}, 2'd0);
			OFS_DATA + BYTE1: next_rdata = lane({8'h00, data_word}, 2'd1);
			OFS_ACC: next_rdata = lane({8'h00, acc}, 2'd0);
			OFS_ACC + BYTE1: next_rdata = lane({8'h00, acc}, 2'd1);
			OFS_SHIFT: next_rdata = lane({8'h00, shifter}, 2'd0);
			OFS_SHIFT + BYTE1: next_rdata = lane({8'h00, shifter}, 2'd1);
			OFS_TAPS: next_rdata = {taps[7:1], 1'b1};
			OFS_TAPS + BYTE1: next_rdata = taps[15:8];
			OFS_CRC_CON: next_rdata = {crc_con[7:6], crc_busy,
				crc_con[4], 2'b00, crc_con[1], full};
			OFS_LEN_CFG: next_rdata = len_cfg;
			default: next_rdata = 8'h00;
		endcase
	end

	always_ff @(posedge clock or negedge rstn) begin
		if (!rstn)
			rdata <= 8'h00;
		else
			rdata <= rd ? next_rdata : 8'h00;
	end

	// ==========================================
	// Checks
	default clocking @(posedge clock); endclocking
	default disable iff (!rstn);

	sequence s_armed_read;
		(dbg == DBG_WAIT) && done;
	endsequence

	sequence s_step_ready;
		single_step && (dbg == DBG_RUN) && !data_breakpoint
			&& !ext_halt_req && !software_breakpoint_on_go && cc_mode && scan_want;
	endsequence

	a_dbp_halt: assert property (data_breakpoint && dbg == DBG_RUN
		|=> debug_halt)
		else $error("no halt after data breakpoint");
	a_dbp_defer: assert property (data_breakpoint && !reading
		|=> !reading)
		else $error("scan not deferred");
	a_ext_burst: assert property (ext_halt_req && !data_breakpoint
		&& !software_breakpoint_on_go && dbg == DBG_RUN && reading && !nvm_ack
		&& scan_usable
		|=> dbg == DBG_WAIT && nvm_req)
		else $error("burst access cut short");
	a_armed_halt: assert property (s_armed_read |=> debug_halt)
		else $error("no halt after armed read");
	a_step_read: assert property (s_step_ready
		|=> reading ##0 !debug_halt)
		else $error("step read missing");
	a_software_breakpoint_first: assert property (software_breakpoint && !single_step
		&& !data_breakpoint && !ext_halt_req && !software_breakpoint_on_go
		&& dbg == DBG_RUN && cc_mode && reading && !nvm_ack
		|=> !debug_halt)
		else $error("halt before scan");
	a_go_resume: assert property (debug_halt && debug_exit && resume_go
		&& scan_usable && !(scan_wr && addr == OFS_SCAN_CON)
		|=> scan_go)
		else $error("burst not resumed");
	a_halt_freeze: assert property (debug_halt && !reading && !debug_exit
		|=> !reading [*2])
		else $error("scan while halted");
	a_unit_off: assert property (!scan_usable |=> !reading)
		else $error("scan while disabled");
	a_range_end: assert property (done && low_addr == high_addr
		&& !scan_wr |=> invalid)
		else $error("scan passed end");

endmodule : crs_top
`default_nettype wire

// [rtl/crs_pkg.sv]
package crs_pkg;

	// ==========================================
	// Register byte addresses
	localparam logic [11:0] OFS_LOW_ADDR  = 12'hf49;
	localparam logic [11:0] OFS_HIGH_ADDR = 12'hf4c;
	localparam logic [11:0] OFS_SCAN_CON  = 12'hf4f;
	localparam logic [11:0] OFS_TRIG_SEL  = 12'hf50;
	localparam logic [11:0] OFS_DATA      = 12'hf74;
	localparam logic [11:0] OFS_ACC       = 12'hf76;
	localparam logic [11:0] OFS_SHIFT     = 12'hf78;
	localparam logic [11:0] OFS_TAPS      = 12'hf7a;
	localparam logic [11:0] OFS_CRC_CON   = 12'hf7c;
	localparam logic [11:0] OFS_LEN_CFG   = 12'hf7d;
	localparam logic [11:0] BYTE1         = 12'h001;
	localparam logic [11:0] BYTE2         = 12'h002;

	// ==========================================
	// Field positions
	localparam int CC_EN   = 7;
	localparam int CC_GO   = 6;
	localparam int CC_ZERO_AUGMENT_SELECT = 4;
	localparam int CC_SHR  = 1;
	localparam int SC_EN   = 7;
	localparam int SC_GO   = 6;
	localparam int SC_INTERRUPT_PRIORITY_SELECT = 3;

	// ==========================================
	// Reset values and sizes
	localparam logic [7:0]  CRC_CON_RST = 8'h00;
	localparam logic [7:0]  LEN_CFG_RST = 8'h00;
	localparam logic [15:0] ACC_RST     = 16'h0000;
	localparam logic [21:0] ADDR_RST    = 22'h000000;
	localparam int          NVM_AW      = 22;

	// ==========================================
	// Types
	typedef enum logic [1:0] {
		SM_CONC  = 2'b00,
		SM_BURST = 2'b01,
		SM_PEEK  = 2'b10,
		SM_TRIG  = 2'b11
	} crs_mode_t;

	typedef enum logic [1:0] {
		DBG_RUN  = 2'b00,
		DBG_WAIT = 2'b01,
		DBG_HALT = 2'b10
	} crs_dbg_t;

	typedef struct packed {
		logic [15:0] taps;
		logic [3:0]  word_length_minus_one;
		logic [3:0]  poly_length_minus_one;
		logic        zero_augment_select;
		logic        shr;
		logic        go;
	} crs_cfg_t;

endpackage : crs_pkg

// [rtl/crs_core.sv]
`timescale 1ns/1ps
`default_nettype none
module crs_core
	import crs_pkg::*;
#(
	parameter int W = 16
) (
	// Clock and reset
	input  wire logic         clock,
	input  wire logic         rstn,
	// Control
	input  wire logic         clear,
	input  wire crs_cfg_t     cfg,
	// Data word loading
	input  wire logic [1:0]   dat_we,
	input  wire logic         load_valid,
	input  wire logic [W-1:0] load_data,
	// Accumulator writes
	input  wire logic [1:0]   acc_we,
	input  wire logic [7:0]   wbyte,
	// State
	output logic      [W-1:0] data_word,
	output logic      [W-1:0] acc,
	output logic      [W-1:0] shifter,
	output logic              full,
	output logic              busy
);

	logic         shifting;
	logic [3:0]   cnt;
	logic         take;
	logic         bit_in;
	logic         top;
	logic         fb;
	logic [W-1:0] mask;
	logic [W-1:0] shl_acc;
	logic [W-1:0] shr_acc;
	logic [W-1:0] next_acc;

	if (W != 16) begin : g_chk
		$error("crs_core serves W of 16 only");
	end

	// ==========================================
	// Feedback
	assign take     = cfg.go && full && !shifting && !(|dat_we) && !load_valid;
	assign bit_in   = cfg.shr ? shifter[0] : shifter[cfg.word_length_minus_one];
	assign top      = cfg.shr ? acc[0] : acc[cfg.poly_length_minus_one];
	assign fb       = cfg.zero_augment_select ? top : (top ^ bit_in);
	assign mask     = ~({{(W-1){1'b1}}, 1'b0} << cfg.poly_length_minus_one);
	assign shl_acc  = {acc[W-2:0], cfg.zero_augment_select & bit_in};
	assign shr_acc  = (acc >> 1) | ((cfg.zero_augment_select & bit_in) ? (mask ^ (mask >> 1)) : '0);
	assign next_acc = ((cfg.shr ? shr_acc : shl_acc) ^ (fb ? cfg.taps : '0)) & mask;
	assign busy     = full || shifting;

	// ==========================================
	// Data word
	always_ff @(posedge clock or negedge rstn) begin
		if (!rstn) begin
			data_word <= '0;
			full      <= 1'b0;
		end else if (clear) begin
			full <= 1'b0;
		end else if (load_valid) begin
			data_word <= load_data;
			full      <= 1'b1;
		end else if (|dat_we) begin
			if (dat_we[0])
				data_word[7:0] <= wbyte;
			if (dat_we[1])
				data_word[15:8] <= wbyte;
			full <= full || dat_we[1] || !cfg.word_length_minus_one[3];
		end else if (take) begin
			full <= 1'b0;
		end
	end

	// ==========================================
	// Shifter
	always_ff @(posedge clock or negedge rstn) begin
		if (!rstn) begin
			shifting <= 1'b0;
			cnt      <= 4'h0;
			shifter  <= '0;
		end else if (clear) begin
			shifting <= 1'b0;
			shifter  <= '0;
		end else if (take) begin
			shifter  <= data_word;
			cnt      <= cfg.word_length_minus_one;
			shifting <= 1'b1;
		end else if (shifting && cfg.go) begin
			shifter  <= cfg.shr ? (shifter >> 1) : (shifter << 1);
			cnt      <= cnt - 4'h1;
			shifting <= (cnt != 4'h0);
		end
	end

	// ==========================================
	// Accumulator
	always_ff @(posedge clock or negedge rstn) begin
		if (!rstn)
			acc <= ACC_RST;
		else if (clear)
			acc <= ACC_RST;
		else if (|acc_we) begin
			if (acc_we[0])
				acc[7:0] <= wbyte;
			if (acc_we[1])
				acc[15:8] <= wbyte;
		end else if (shifting && cfg.go)
			acc <= next_acc;
	end

	// ==========================================
	// Checks
	default clocking @(posedge clock); endclocking
	default disable iff (!rstn);

	a_word_take: assert property (take && !clear |=> !full && shifting)
		else $error("data word not taken");
	a_word_len: assert property (take && !clear |=> cnt == $past(cfg.word_length_minus_one))
		else $error("bit count wrong");
	a_go_stop: assert property (!cfg.go && !clear && !(|acc_we) |=> $stable(acc))
		else $error("shift while stopped");
	a_clear_idle: assert property (clear |=> !busy && acc == ACC_RST)
		else $error("unit not held");

endmodule : crs_core
`default_nettype wire

// [sim/crs_nvm_model.sv]
`timescale 1ns/1ps
`default_nettype none
module crs_nvm_model
	import crs_pkg::*;
(
	// Clock and reset
	input  wire logic              clock,
	input  wire logic              rstn,
	// Memory port
	input  wire logic              nvm_req,
	input  wire logic [NVM_AW-1:0] nvm_addr,
	input  wire logic [3:0]        lat,
	output logic                   nvm_ack,
	output logic      [15:0]       nvm_data
);
	logic [3:0] cnt;

	// ==========================================
	// Answer after lat cycles, else toggling data
	always_ff @(posedge clock or negedge rstn) begin
		if (!rstn) begin
			cnt <= 4'h0;
			nvm_ack <= 1'b0;
			nvm_data <= 16'h0000;
		end else if (nvm_req && !nvm_ack && cnt >= lat) begin
			cnt <= 4'h0;
			nvm_ack <= 1'b1;
			nvm_data <= {nvm_addr[7:0], ~nvm_addr[7:0]};
		end else begin
			cnt <= nvm_req ? cnt + 4'h1 : 4'h0;
			nvm_ack <= 1'b0;
			nvm_data <= ~nvm_data;
		end
	end
endmodule : crs_nvm_model
`default_nettype wire

// [sim/crs_top_tb.sv]
`timescale 1ns/1ps
`default_nettype none
`define CHK(n, e, g) begin num_checks++; if ((g) !== (e)) begin \
	err_total++; $display("[FAIL] %s exp %h got %h", n, e, g); end end
module crs_top_tb
	import crs_pkg::*;
;
	logic              clock, rstn, wr, rd, nvm_req, nvm_ack, cpu_stall;
	logic              checksum_unit_disable, scanner_unit_disable;
	logic              scanner_available_config, debug_halt;
	logic              ext_halt_req, data_breakpoint, single_step;
	logic              debug_exit, software_breakpoint_on_go;
	logic [11:0]       addr;
	logic [7:0]        wdata, rdata, v;
	logic [15:0]       nvm_data, w;
	logic [NVM_AW-1:0] nvm_addr;
	logic [3:0]        lat;
	int                err_total, num_checks, k;

	crs_top uut (.clock(clock), .rstn(rstn), .addr(addr), .wdata(wdata),
		.wr(wr), .rd(rd), .rdata(rdata),
		.checksum_unit_disable(checksum_unit_disable),
		.scanner_unit_disable(scanner_unit_disable),
		.scanner_available_config(scanner_available_config),
		.nvm_req(nvm_req), .nvm_addr(nvm_addr), .nvm_ack(nvm_ack),
		.nvm_data(nvm_data), .cpu_dead_cycle(1'b0),
		.cpu_in_interrupt(1'b0), .triggers(16'h0000),
		.cpu_stall(cpu_stall), .ext_halt_req(ext_halt_req),
		.data_breakpoint(data_breakpoint), .single_step(single_step),
		.software_breakpoint(1'b0), .software_breakpoint_on_go(software_breakpoint_on_go),
		.debug_exit(debug_exit), .debug_halt(debug_halt));
	crs_nvm_model mem (.clock(clock), .rstn(rstn), .nvm_req(nvm_req),
		.nvm_addr(nvm_addr), .lat(lat), .nvm_ack(nvm_ack),
		.nvm_data(nvm_data));

	initial begin
		clock = 1'b0;
		forever #50 clock = ~clock;
	end

	// ==========================================
	// Register port tasks
	task automatic wr8(input logic [11:0] a, input logic [7:0] d);
		@(posedge clock);
		addr <= a;
		wdata <= d;
		wr <= 1'b1;
		@(posedge clock);
		wr <= 1'b0;
	endtask : wr8
	task automatic rd8(input logic [11:0] a, output logic [7:0] d);
		@(posedge clock);
		addr <= a;
		rd <= 1'b1;
		@(posedge clock);
		rd <= 1'b0;
		#1;
		d = rdata;
	endtask : rd8
	task automatic wr16(input logic [11:0] a, input logic [15:0] d);
		wr8(a, d[7:0]);
		wr8(a + BYTE1, d[15:8]);
	endtask : wr16
	task automatic wr24(input logic [11:0] a, input logic [23:0] d);
		wr16(a, d[15:0]);
		wr8(a + BYTE2, d[23:16]);
	endtask : wr24
	task automatic chk8(input string n, input logic [11:0] a,
		input logic [7:0] e);
		logic [7:0] d;
		rd8(a, d);
		`CHK(n, e, d)
	endtask : chk8
	task automatic chk16(input string n, input logic [11:0] a,
		input logic [15:0] e);
		logic [7:0] lo;
		logic [7:0] hi;
		rd8(a, lo);
		rd8(a + BYTE1, hi);
		`CHK(n, e, {hi, lo})
	endtask : chk16
	task automatic tally_and_finish();
		$display("checks %0d errors %0d", num_checks, err_total);
		if (err_total == 0 && num_checks > 0)
			$display("Result: passed");
		else
			$display("Result: failed");
		$finish;
	endtask : tally_and_finish
	task automatic wait_bit(input logic [11:0] a, input int b);
		logic [7:0] d;
		int i;
		d = 8'hff;
		for (i = 0; i < 100 && d[b] !== 1'b0; i++)
			rd8(a, d);
		if (d[b] !== 1'b0) begin
			err_total++;
			$display("[FAIL] wait on register bit timed out");
			tally_and_finish();
		end
	endtask : wait_bit
	task automatic wait_port(input int s);
		int i;
		for (i = 0; i < 30; i++) begin
			@(posedge clock);
			#1;
			if ((s == 0 ? nvm_req : nvm_ack) === 1'b1)
				return;
		end
		err_total++;
		$display("[FAIL] wait on memory port timed out");
		tally_and_finish();
	endtask : wait_port
	task automatic dbg(input int s);
		@(posedge clock);
		data_breakpoint <= (s == 0);
		single_step <= (s == 1);
		ext_halt_req <= (s == 2);
		debug_exit <= (s == 3);
		software_breakpoint_on_go <= (s == 5);
		@(posedge clock);
		{data_breakpoint, single_step, ext_halt_req, debug_exit} <= 4'h0;
		software_breakpoint_on_go <= 1'b0;
		#1;
	endtask : dbg

	function automatic logic [15:0] crc_ref(input logic [15:0] a,
		input logic [15:0] d, input logic [7:0] len, input logic [15:0] t,
		input logic am, input logic sr);
		logic b, top, fb;
		int i;
		for (i = len[7:4]; i >= 0; i--) begin
			b = sr ? d[len[7:4] - i] : d[i];
			top = sr ? a[0] : a[len[3:0]];
			fb = am ? top : top ^ b;
			a = sr ? a >> 1 : a << 1;
			if (am)
				a = a | (sr ? {15'h0, b} << len[3:0] : {15'h0, b});
			if (fb)
				a = a ^ (t | 16'h0001);
			a = a & (16'hffff >> (4'hf - len[3:0]));
		end
		return a;
	endfunction : crc_ref

	// ==========================================
	// Main sequence
	initial begin
		{rstn, wr, rd, addr, wdata, checksum_unit_disable} = '0;
		{scanner_unit_disable, ext_halt_req, data_breakpoint} = '0;
		{single_step, debug_exit, software_breakpoint_on_go, err_total, num_checks} = '0;
		scanner_available_config = 1'b1;
		lat = 4'h2;
		repeat (20) @(posedge clock);
		rstn <= 1'b1;
		chk8("crc_con", OFS_CRC_CON, CRC_CON_RST);
		chk8("len_cfg", OFS_LEN_CFG, LEN_CFG_RST);
		chk8("scan_con", OFS_SCAN_CON, 8'h10);
		chk8("taps_lo", OFS_TAPS, 8'h01);
		chk8("unmapped", 12'hf60, 8'h00);
		for (k = 0; k < 4; k++) begin
			wr8(OFS_CRC_CON, 8'h00);
			wr8(OFS_LEN_CFG, 8'h77);
			wr16(OFS_TAPS, 16'h0007);
			wr8(OFS_CRC_CON, {3'b110, k[1], 2'b00, k[0], 1'b0});
			wr8(OFS_DATA, 8'ha5);
			wait_bit(OFS_CRC_CON, 5);
			w = crc_ref(16'h0, 16'h00a5, 8'h77, 16'h0007, k[1], k[0]);
			chk16("acc8", OFS_ACC, w);
		end
		wr8(OFS_CRC_CON, 8'h00);
		chk16("acc_clr", OFS_ACC, 16'h0000);
		wr8(OFS_LEN_CFG, 8'hff);
		wr16(OFS_TAPS, 16'h1021);
		wr8(OFS_CRC_CON, 8'h80);
		wr8(OFS_DATA, 8'h34);
		chk8("full_lo", OFS_CRC_CON, 8'h80);
		wr8(OFS_DATA + BYTE1, 8'h12);
		repeat (3) @(posedge clock);
		rd8(OFS_CRC_CON, v);
		`CHK("busy_held", 1'b1, v[5])
		chk16("acc_held", OFS_ACC, 16'h0000);
		wr8(OFS_CRC_CON, 8'hc0);
		rd8(OFS_CRC_CON, v);
		wr16(OFS_DATA, 16'hbeef);
		chk8("full_hi", OFS_CRC_CON, 8'he1);
		wait_bit(OFS_CRC_CON, 5);
		w = crc_ref(16'h0, 16'h1234, 8'hff, 16'h1021, 1'b0, 1'b0);
		w = crc_ref(w, 16'hbeef, 8'hff, 16'h1021, 1'b0, 1'b0);
		chk16("acc16", OFS_ACC, w);
		chk8("idle", OFS_CRC_CON, 8'hc0);
		checksum_unit_disable <= 1'b1;
		wr8(OFS_LEN_CFG, 8'h12);
		checksum_unit_disable <= 1'b0;
		chk8("crc_off", OFS_LEN_CFG, 8'hff);
		scanner_unit_disable <= 1'b1;
		wr8(OFS_TRIG_SEL, 8'h05);
		{scanner_unit_disable, scanner_available_config} <= 2'b10;
		wr8(OFS_TRIG_SEL, 8'h06);
		{scanner_unit_disable, scanner_available_config} <= 2'b01;
		chk8("scan_off", OFS_TRIG_SEL, 8'h00);
		wr24(OFS_LOW_ADDR, 24'h000010);
		wr24(OFS_HIGH_ADDR, 24'h000011);
		for (k = 0; k < 4; k++) begin
			wr8(OFS_SCAN_CON, 8'h80 | k[7:0]);
			chk8("mode", OFS_SCAN_CON, 8'h80 | k[7:0]);
		end
		for (k = 1; k < 3; k++) begin
			dbg(k);
			`CHK("halt", 1'b1, debug_halt)
			dbg(3);
			`CHK("run", 1'b0, debug_halt)
		end
		wr8(OFS_CRC_CON, 8'h00);
		wr8(OFS_CRC_CON, 8'hc0);
		dbg(0);
		`CHK("bp_halt", 1'b1, debug_halt)
		wr8(OFS_SCAN_CON, 8'hc0);
		repeat (4) @(posedge clock);
		#1;
		`CHK("frozen", 1'b0, nvm_req)
		rd8(OFS_SCAN_CON, v);
		`CHK("scan_view", 2'b11, v[7:6])
		dbg(3);
		wait_port(0);
		`CHK("nvm_addr", 22'h000010, nvm_addr)
		wait_bit(OFS_SCAN_CON, 6);
		wait_bit(OFS_CRC_CON, 5);
		w = crc_ref(16'h0, 16'h10ef, 8'hff, 16'h1021, 1'b0, 1'b0);
		w = crc_ref(w, 16'h11ee, 8'hff, 16'h1021, 1'b0, 1'b0);
		chk16("scan_acc", OFS_ACC, w);
		chk8("scan_adr", OFS_LOW_ADDR, 8'h12);
		chk8("scan_end", OFS_SCAN_CON, 8'h90);
		lat <= 4'h6;
		wr24(OFS_LOW_ADDR, 24'h000020);
		wr24(OFS_HIGH_ADDR, 24'h000021);
		wr8(OFS_CRC_CON, 8'h00);
		wr8(OFS_CRC_CON, 8'hc0);
		wr8(OFS_SCAN_CON, 8'hc1);
		wait_port(0);
		`CHK("stall", 1'b1, cpu_stall)
		dbg(2);
		wait_port(1);
		@(posedge clock);
		#1;
		`CHK("burst_halt", 1'b1, debug_halt)
		repeat (3) @(posedge clock);
		#1;
		`CHK("burst_frozen", 1'b0, nvm_req)
		dbg(3);
		wait_bit(OFS_SCAN_CON, 6);
		wait_bit(OFS_CRC_CON, 5);
		w = crc_ref(16'h0, 16'h20df, 8'hff, 16'h1021, 1'b0, 1'b0);
		w = crc_ref(w, 16'h21de, 8'hff, 16'h1021, 1'b0, 1'b0);
		chk16("burst_acc", OFS_ACC, w);
		wr24(OFS_HIGH_ADDR, 24'h000022);
		dbg(5);
		`CHK("software_breakpoint_halt", 1'b1, debug_halt)
		dbg(3);
		wait_bit(OFS_SCAN_CON, 6);
		chk8("go_adr", OFS_LOW_ADDR, 8'h23);
		tally_and_finish();
	end
endmodule : crs_top_tb
`default_nettype wire
